// >>> extended_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"

module extended_timer (
	input  wire logic      clk,
	input  wire logic      srst,
	timer_link_if.device   link,
	input  wire logic      capture_one_event,
	input  wire logic      capture_two_event,
	input  wire logic      compare_one_match,
	input  wire logic      compare_two_match,
	input  wire logic      count_tick,
	input  wire logic      ext_irq_pin,
	output var  timer_pkg::count_t count_value,
	output var  timer_pkg::count_t compare_one_value,
	output var  timer_pkg::count_t compare_two_value,
	output var  timer_pkg::byte_t  timer_control_two
);
	import timer_pkg::*;

	byte_t  timer_control_one;
	byte_t  timer_control_three;
	count_t capture_one;
	count_t capture_two;
	byte_t  timer_status_reg;
	byte_t  next_rdata;
	logic   ext_meta, ext_sync;
	logic   rd_acc, wr_acc, status_acc;
	logic   cap1_lo_acc, cap2_lo_acc, cmp1_lo_acc, cmp2_lo_acc, count_lo_acc;
	logic   count_reload, overflow_event;
	logic   capture_one_flag, capture_two_flag, compare_one_flag;
	logic   compare_two_flag, overflow_flag;
	logic   cap1_en, cap2_en, cmp1_en, cmp2_en;
	logic   timer_req, req_latched;

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	// word transfers are not supported; every access is one byte
	assign rd_acc       = link.acc_valid && !link.acc_write;
	assign wr_acc       = link.acc_valid && link.acc_write;
	assign status_acc   = link.acc_valid && (link.acc_addr == `OFS_STATUS);
	assign cap1_lo_acc  = link.acc_valid && (link.acc_addr == `OFS_CAP1_LO);
	assign cap2_lo_acc  = link.acc_valid && (link.acc_addr == `OFS_CAP2_LO);
	assign cmp1_lo_acc  = link.acc_valid && (link.acc_addr == `OFS_CMP1_LO);
	assign cmp2_lo_acc  = link.acc_valid && (link.acc_addr == `OFS_CMP2_LO);
	assign count_lo_acc = link.acc_valid && (link.acc_addr == `OFS_COUNT_LO);
	// either low counter byte written restarts the count
	assign count_reload = wr_acc
		&& (link.acc_addr == `OFS_COUNT_LO || link.acc_addr == `OFS_ALT_LO);
	assign overflow_event = count_tick && !count_reload
		&& (count_value == `COUNT_WRAP);

	// ----------------------------------------
	// external interrupt input
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			ext_meta <= ext_irq_pin;
			ext_sync <= ext_meta;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			timer_control_one   <= `CTRL_RESET;
			timer_control_two   <= `CTRL_RESET;
			timer_control_three <= `CTRL_RESET;
		end else if (wr_acc) begin
			if (link.acc_addr == `OFS_CTRL_ONE) timer_control_one <= link.acc_wdata;
			else if (link.acc_addr == `OFS_CTRL_TWO) timer_control_two <= link.acc_wdata;
			else if (link.acc_addr == `OFS_CTRL_THR)
				timer_control_three <= link.acc_wdata & `CTRL_THR_WMASK;
		end
	end

	// ----------------------------------------
	// compare value registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			compare_one_value <= {`CMP_HI_RESET, `CMP_LO_RESET};
			compare_two_value <= {`CMP_HI_RESET, `CMP_LO_RESET};
		end else if (wr_acc) begin
			if (link.acc_addr == `OFS_CMP1_HI) compare_one_value[15:8] <= link.acc_wdata;
			else if (link.acc_addr == `OFS_CMP1_LO) compare_one_value[7:0] <= link.acc_wdata;
			else if (link.acc_addr == `OFS_CMP2_HI) compare_two_value[15:8] <= link.acc_wdata;
			else if (link.acc_addr == `OFS_CMP2_LO) compare_two_value[7:0] <= link.acc_wdata;
		end
	end

	// ----------------------------------------
	// free-running counter
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst)
			count_value <= `COUNT_RESET;
		else if (count_reload)
			count_value <= `COUNT_RESET;
		else if (count_tick)
			count_value <= count_value + 16'h0001;
	end

	// ----------------------------------------
	// capture registers
	// ----------------------------------------
	// no reset on purpose: contents undefined until the first capture
	always_ff @(posedge clk) begin
		if (capture_one_event)
			capture_one <= count_value;
		if (capture_two_event)
			capture_two <= count_value;
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	flag_cell u_cap1 (
		.clk           (clk),
		.srst          (srst),
		.set_event     (capture_one_event),
		.status_access (status_acc),
		.low_access    (cap1_lo_acc),
		.flag          (capture_one_flag)
	);
	flag_cell u_cap2 (
		.clk           (clk),
		.srst          (srst),
		.set_event     (capture_two_event),
		.status_access (status_acc),
		.low_access    (cap2_lo_acc),
		.flag          (capture_two_flag)
	);
	flag_cell u_cmp1 (
		.clk           (clk),
		.srst          (srst),
		.set_event     (compare_one_match),
		.status_access (status_acc),
		.low_access    (cmp1_lo_acc),
		.flag          (compare_one_flag)
	);
	flag_cell u_cmp2 (
		.clk           (clk),
		.srst          (srst),
		.set_event     (compare_two_match),
		.status_access (status_acc),
		.low_access    (cmp2_lo_acc),
		.flag          (compare_two_flag)
	);
	// alternate low byte is not wired here, so it never clears overflow
	flag_cell u_ovf (
		.clk           (clk),
		.srst          (srst),
		.set_event     (overflow_event),
		.status_access (status_acc),
		.low_access    (count_lo_acc),
		.flag          (overflow_flag)
	);

	always_comb begin
		timer_status_reg          = `BYTE_ZERO;
		timer_status_reg[`SR_CAP1] = capture_one_flag;
		timer_status_reg[`SR_CMP1] = compare_one_flag;
		timer_status_reg[`SR_OVF]  = overflow_flag;
		timer_status_reg[`SR_CAP2] = capture_two_flag;
		timer_status_reg[`SR_CMP2] = compare_two_flag;
	end

	// ----------------------------------------
	// interrupt request
	// ----------------------------------------
	// group bit overrides the per-channel pair
	assign cap1_en = timer_control_one[`C1_CAP_GROUP]
		|| timer_control_three[`C3_CAP1_EN];
	assign cap2_en = timer_control_one[`C1_CAP_GROUP]
		|| timer_control_three[`C3_CAP2_EN];
	assign cmp1_en = timer_control_one[`C1_CMP_GROUP]
		|| timer_control_three[`C3_CMP1_EN];
	assign cmp2_en = timer_control_one[`C1_CMP_GROUP]
		|| timer_control_three[`C3_CMP2_EN];
	assign timer_req = (capture_one_flag && cap1_en)
		|| (capture_two_flag && cap2_en)
		|| (compare_one_flag && cmp1_en)
		|| (compare_two_flag && cmp2_en)
		|| (overflow_flag && timer_control_one[`C1_OVF_EN]);

	// stays high until every flag is zero at once, so no edge is lost
	// but a handler that never empties the status locks the channel
	always_ff @(posedge clk) begin
		if (srst)
			req_latched <= 1'b0;
		else if (timer_req)
			req_latched <= 1'b1;
		else if (timer_status_reg == `BYTE_ZERO)
			req_latched <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (srst)
			link.irq_channel <= 1'b0;
		else if (timer_control_three[`C3_SRC_SEL])
			link.irq_channel <= req_latched;
		else
			link.irq_channel <= ext_sync;
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_comb begin
		next_rdata = `BYTE_ZERO;
		if (link.acc_addr == `OFS_CAP1_HI) next_rdata = capture_one[15:8];
		else if (link.acc_addr == `OFS_CAP1_LO) next_rdata = capture_one[7:0];
		else if (link.acc_addr == `OFS_CAP2_HI) next_rdata = capture_two[15:8];
		else if (link.acc_addr == `OFS_CAP2_LO) next_rdata = capture_two[7:0];
		else if (link.acc_addr == `OFS_COUNT_HI || link.acc_addr == `OFS_ALT_HI)
			next_rdata = count_value[15:8];
		else if (link.acc_addr == `OFS_COUNT_LO || link.acc_addr == `OFS_ALT_LO)
			next_rdata = count_value[7:0];
		else if (link.acc_addr == `OFS_CMP1_HI) next_rdata = compare_one_value[15:8];
		else if (link.acc_addr == `OFS_CMP1_LO) next_rdata = compare_one_value[7:0];
		else if (link.acc_addr == `OFS_CMP2_HI) next_rdata = compare_two_value[15:8];
		else if (link.acc_addr == `OFS_CMP2_LO) next_rdata = compare_two_value[7:0];
		else if (link.acc_addr == `OFS_CTRL_ONE) next_rdata = timer_control_one;
		else if (link.acc_addr == `OFS_CTRL_TWO) next_rdata = timer_control_two;
		else if (link.acc_addr == `OFS_STATUS) next_rdata = timer_status_reg;
		else if (link.acc_addr == `OFS_CTRL_THR) next_rdata = timer_control_three;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			link.acc_done  <= 1'b0;
			link.acc_rdata <= `BYTE_ZERO;
		end else begin
			link.acc_done <= link.acc_valid;
			if (rd_acc)
				link.acc_rdata <= next_rdata;
		end
	end
endmodule // extended_timer

`default_nettype wire

// >>> timer_cfg.svh
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ----------------------------------------
// device register offsets
// ----------------------------------------
`define OFS_CAP1_HI   8'hF0
`define OFS_CAP1_LO   8'hF1
`define OFS_CAP2_HI   8'hF2
`define OFS_CAP2_LO   8'hF3
`define OFS_COUNT_HI  8'hF4
`define OFS_COUNT_LO  8'hF5
`define OFS_ALT_HI    8'hF6
`define OFS_ALT_LO    8'hF7
`define OFS_CMP1_HI   8'hF8
`define OFS_CMP1_LO   8'hF9
`define OFS_CMP2_HI   8'hFA
`define OFS_CMP2_LO   8'hFB
`define OFS_CTRL_ONE  8'hFC
`define OFS_CTRL_TWO  8'hFD
`define OFS_STATUS    8'hFE
`define OFS_CTRL_THR  8'hFF

// ----------------------------------------
// device reset values
// ----------------------------------------
`define COUNT_RESET   16'hFFFC
`define COUNT_WRAP    16'hFFFF
`define CMP_HI_RESET  8'h80
`define CMP_LO_RESET  8'h00
`define CTRL_RESET    8'h00
`define BYTE_ZERO     8'h00
`define CTRL_THR_WMASK 8'hF1

// ----------------------------------------
// device field positions
// ----------------------------------------
`define SR_CAP1       7
`define SR_CMP1       6
`define SR_OVF        5
`define SR_CAP2       4
`define SR_CMP2       3
`define C1_CAP_GROUP  7
`define C1_CMP_GROUP  6
`define C1_OVF_EN     5
`define C3_CAP1_EN    7
`define C3_CMP1_EN    6
`define C3_CAP2_EN    5
`define C3_CMP2_EN    4
`define C3_SRC_SEL    0

// ----------------------------------------
// host register map
// ----------------------------------------
`define HOST_OFS_ACCESS  8'h00
`define HOST_OFS_RESULT  8'h04
`define HOST_OFS_CHANNEL 8'h08
`define HOST_OFS_PENDING 8'h0C
`define ACC_WRITE_BIT    16
`define ACC_ADDR_MSB     15
`define ACC_ADDR_LSB     8
`define ACC_DATA_MSB     7
`define RES_BUSY_BIT     31
`define RES_IRQ_BIT      30
`define CH_TRIG_BIT      0
`define CH_MASK_BIT      1
`define CH_PRIO_LSB      4
`define CH_PRIO_MSB      6
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define WORD_ZERO        32'h0000_0000

`endif

// >>> timer_pkg.sv
package timer_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [15:0] count_t;
	typedef logic [2:0]  prio_t;
	typedef enum {ACC_IDLE, ACC_WAIT} host_acc_state_t;
endpackage

// >>> timer_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface timer_link_if;
	import timer_pkg::*;
	logic  acc_valid;
	logic  acc_write;
	byte_t acc_addr;
	byte_t acc_wdata;
	logic  acc_done;
	byte_t acc_rdata;
	logic  irq_channel;

	modport device (
		input  acc_valid,
		input  acc_write,
		input  acc_addr,
		input  acc_wdata,
		output acc_done,
		output acc_rdata,
		output irq_channel
	);
	modport host (
		output acc_valid,
		output acc_write,
		output acc_addr,
		output acc_wdata,
		input  acc_done,
		input  acc_rdata,
		input  irq_channel
	);
endinterface

`default_nettype wire

// >>> flag_cell.sv
`timescale 1ns/1ps
`default_nettype none

module flag_cell (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic set_event,
	input  wire logic status_access,
	input  wire logic low_access,
	output var  logic flag
);
	logic armed;

	// ----------------------------------------
	// two-step clear, set wins
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst)
			armed <= 1'b0;
		else if (status_access)
			armed <= flag;
		else if (low_access)
			armed <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (srst)
			flag <= 1'b0;
		else if (set_event)
			flag <= 1'b1;
		else if (low_access && armed)
			flag <= 1'b0;
	end
endmodule // flag_cell

`default_nettype wire

// >>> timer_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"

module timer_host (
	input  wire logic         clk,
	input  wire logic         srst,
	timer_link_if.host        link,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output var  logic         s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output var  logic         s_axi_wready,
	output var  logic [1:0]   s_axi_bresp,
	output var  logic         s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output var  logic         s_axi_arready,
	output var  logic [31:0]  s_axi_rdata,
	output var  logic [1:0]   s_axi_rresp,
	output var  logic         s_axi_rvalid,
	input  wire logic         s_axi_rready,
	output var  logic         cpu_irq,
	output var  timer_pkg::prio_t cpu_irq_priority
);
	import timer_pkg::*;

	host_acc_state_t state;
	byte_t           result;
	logic            channel_trigger_reg;
	logic            channel_mask;
	logic            channel_pending_reg;
	logic            irq_prev;
	logic            edge_seen;
	logic            wr_take;
	logic            start_acc;
	logic            clear_pending;
	logic [31:0]     next_rdata;
	logic [1:0]      next_rresp;

	// ----------------------------------------
	// axi write side
	// ----------------------------------------
	assign wr_take = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	// a new access while busy is dropped; software polls busy first
	assign start_acc = wr_take && (s_axi_awaddr == `HOST_OFS_ACCESS)
		&& s_axi_wstrb[0] && (state == ACC_IDLE);
	assign clear_pending = wr_take && (s_axi_awaddr == `HOST_OFS_PENDING)
		&& s_axi_wdata[0];

	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
				&& !s_axi_bvalid;
			s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
				&& !s_axi_bvalid;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (wr_take) begin
			s_axi_bvalid <= 1'b1;
			if (s_axi_awaddr == `HOST_OFS_ACCESS || s_axi_awaddr == `HOST_OFS_CHANNEL
				|| s_axi_awaddr == `HOST_OFS_PENDING)
				s_axi_bresp <= `RESP_OKAY;
			else
				s_axi_bresp <= `RESP_SLVERR;
		end else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ----------------------------------------
	// channel controller
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			channel_trigger_reg <= 1'b0;
			channel_mask        <= 1'b0;
			cpu_irq_priority    <= 3'h0;
		end else if (wr_take && s_axi_awaddr == `HOST_OFS_CHANNEL && s_axi_wstrb[0]) begin
			channel_trigger_reg <= s_axi_wdata[`CH_TRIG_BIT];
			channel_mask        <= s_axi_wdata[`CH_MASK_BIT];
			cpu_irq_priority    <= s_axi_wdata[`CH_PRIO_MSB:`CH_PRIO_LSB];
		end
	end

	// trigger bit set selects rising edge, clear selects falling
	assign edge_seen = channel_trigger_reg ? (link.irq_channel && !irq_prev)
		: (!link.irq_channel && irq_prev);

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_prev            <= 1'b0;
			channel_pending_reg <= 1'b0;
		end else begin
			irq_prev <= link.irq_channel;
			if (edge_seen)
				channel_pending_reg <= 1'b1;
			else if (clear_pending)
				channel_pending_reg <= 1'b0;
		end
	end

	// a stale pending bit fires at once on unmasking unless cleared first
	always_ff @(posedge clk) begin
		if (srst)
			cpu_irq <= 1'b0;
		else
			cpu_irq <= channel_pending_reg && channel_mask;
	end

	// ----------------------------------------
	// byte access engine
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state          <= ACC_IDLE;
			link.acc_valid <= 1'b0;
			link.acc_write <= 1'b0;
			link.acc_addr  <= `BYTE_ZERO;
			link.acc_wdata <= `BYTE_ZERO;
			result         <= `BYTE_ZERO;
		end else begin
			case (state)
				ACC_IDLE: begin
					if (start_acc) begin
						// one byte per access, never a word
						link.acc_valid <= 1'b1;
						link.acc_write <= s_axi_wdata[`ACC_WRITE_BIT];
						link.acc_addr  <= s_axi_wdata[`ACC_ADDR_MSB:`ACC_ADDR_LSB];
						link.acc_wdata <= s_axi_wdata[`ACC_DATA_MSB:0];
						state          <= ACC_WAIT;
					end
				end
				ACC_WAIT: begin
					link.acc_valid <= 1'b0;
					if (link.acc_done) begin
						if (!link.acc_write)
							result <= link.acc_rdata;
						state <= ACC_IDLE;
					end
				end
				default: state <= ACC_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// axi read side
	// ----------------------------------------
	always_comb begin
		next_rdata = `WORD_ZERO;
		next_rresp = `RESP_OKAY;
		if (s_axi_araddr == `HOST_OFS_ACCESS)
			next_rdata = `WORD_ZERO;
		else if (s_axi_araddr == `HOST_OFS_RESULT) begin
			next_rdata[`RES_BUSY_BIT]  = (state != ACC_IDLE);
			next_rdata[`RES_IRQ_BIT]   = link.irq_channel;
			next_rdata[`ACC_DATA_MSB:0] = result;
		end else if (s_axi_araddr == `HOST_OFS_CHANNEL) begin
			next_rdata[`CH_TRIG_BIT] = channel_trigger_reg;
			next_rdata[`CH_MASK_BIT] = channel_mask;
			next_rdata[`CH_PRIO_MSB:`CH_PRIO_LSB] = cpu_irq_priority;
		end else if (s_axi_araddr == `HOST_OFS_PENDING)
			next_rdata[0] = channel_pending_reg;
		else
			next_rresp = `RESP_SLVERR;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `WORD_ZERO;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= next_rresp;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // timer_host

`default_nettype wire

// >>> timer_irq_and_count_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// link checks
// ----------------------------------------
module timer_link_props
	import timer_pkg::*;
(
	input wire logic  clk,
	input wire logic  srst,
	input wire logic  acc_valid,
	input wire logic  acc_write,
	input wire byte_t acc_addr,
	input wire byte_t acc_wdata,
	input wire logic  acc_done,
	input wire byte_t acc_rdata,
	input wire logic  irq_channel
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic       sel;
	logic [3:0] sel_age;
	logic [3:0] low_age;
	logic       is_rd;
	logic       low_acc;
	logic       sel_wr;
	assign is_rd = acc_valid && !acc_write;
	assign sel_wr = acc_valid && acc_write && acc_addr == 8'hFF;
	assign low_acc = acc_valid && acc_addr inside {8'hF1, 8'hF3, 8'hF5, 8'hF9, 8'hFB};
	// source select mirrored from control-three writes
	always_ff @(posedge clk) begin
		if (srst)
			sel <= 1'b0;
		else if (sel_wr)
			sel <= acc_wdata[0];
	end
	// age counters saturate, so long idle spans stay cheap
	always_ff @(posedge clk) begin
		if (srst || !sel || sel_wr)
			sel_age <= 4'h0;
		else if (sel_age != 4'hF)
			sel_age <= sel_age + 4'h1;
	end
	always_ff @(posedge clk) begin
		if (srst || low_acc)
			low_age <= 4'h0;
		else if (low_age != 4'hF)
			low_age <= low_age + 4'h1;
	end
	property p_done; acc_valid |=> acc_done; endproperty
	a_done: assert property (p_done) else $error("no done after access");
	property p_idle; !acc_valid |=> !acc_done; endproperty
	a_idle: assert property (p_idle) else $error("done without access");
	property p_sr_low; is_rd && acc_addr == 8'hFE |=> acc_rdata[2:0] == 3'h0; endproperty
	a_sr_low: assert property (p_sr_low) else $error("status low bits set");
	property p_wr_keep; acc_valid && acc_write |=> $stable(acc_rdata); endproperty
	a_wr_keep: assert property (p_wr_keep) else $error("write moved read data");
	property p_unmapped; is_rd && acc_addr < 8'hF0 |=> acc_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_reload;
		acc_valid && acc_write && acc_addr == 8'hF5 ##[1:60] is_rd && acc_addr == 8'hF4
			|=> acc_rdata == 8'hFF;
	endproperty
	a_reload: assert property (p_reload) else $error("counter not reloaded");
	property p_fall; sel_age > 4'h4 && $fell(irq_channel) |-> low_age <= 4'h6; endproperty
	a_fall: assert property (p_fall) else $error("request dropped without clear");
	property p_rd_only; $changed(acc_rdata) |-> acc_done && $past(is_rd); endproperty
	a_rd_only: assert property (p_rd_only) else $error("read data moved off a read");
	c_irq: cover property (sel && $rose(irq_channel));
	c_flag: cover property (is_rd && acc_addr == 8'hFE ##1 acc_rdata != 8'h00);
	c_reload: cover property (acc_valid && acc_write && acc_addr == 8'hF5);
endmodule // timer_link_props
`default_nettype wire

// >>> timer_irq_and_count_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer_irq_and_count_regs_tb;
	import timer_pkg::*;
	logic        clk = 0;
	logic        srst = 1;
	logic [4:0]  ev = '0;
	logic        ext_pin = 0;
	logic [7:0]  s_axi_awaddr = '0;
	logic [7:0]  s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 0;
	logic        s_axi_wvalid = 0;
	logic        s_axi_bready = 0;
	logic        s_axi_arvalid = 0;
	logic        s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [31:0] res;
	logic        cpu_irq;
	prio_t       cpu_irq_priority;
	count_t      count_value, compare_one_value, compare_two_value;
	byte_t       timer_control_two;
	int          miscompares = 0;
	int          n_compared = 0;
	// per source: ctrl1, ctrl3, status bit, low byte, low value
	byte_t       c1_t[5] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h40};
	byte_t       c3_t[5] = '{8'h01, 8'h41, 8'h01, 8'h21, 8'h01};
	byte_t       bit_t[5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08};
	byte_t       lo_t[5] = '{8'hF1, 8'hF9, 8'hF5, 8'hF3, 8'hFB};
	byte_t       val_t[5] = '{8'hFC, 8'h00, 8'h00, 8'hFC, 8'h00};
	always #2 clk = ~clk;
	timer_link_if link();
	extended_timer i_extended_timer (.clk, .srst, .link(link.device),
		.capture_one_event(ev[0]), .compare_one_match(ev[1]), .count_tick(ev[2]),
		.capture_two_event(ev[3]), .compare_two_match(ev[4]), .ext_irq_pin(ext_pin),
		.count_value, .compare_one_value, .compare_two_value, .timer_control_two);
	timer_host i_timer_host (.clk, .srst, .link(link.host), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.cpu_irq, .cpu_irq_priority);
	timer_link_props i_timer_link_props (.clk, .srst, .acc_valid(link.acc_valid),
		.acc_write(link.acc_write), .acc_addr(link.acc_addr), .acc_wdata(link.acc_wdata),
		.acc_done(link.acc_done), .acc_rdata(link.acc_rdata), .irq_channel(link.irq_channel));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (s_axi_awready && !aw_ok) begin
				aw_ok = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wready && !w_ok) begin
				w_ok = 1;
				s_axi_wvalid <= 0;
			end
		end
		s_axi_bready <= 1;
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk(s_axi_bresp, er);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		s_axi_rready <= 1;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
		d = s_axi_rdata;
		chk(s_axi_rresp, er);
	endtask
	// byte access through the host; read result compared when not a write
	task automatic dev(input logic w, input byte_t a, input byte_t d, input byte_t exp);
		axw(8'h00, {15'h0, w, a, d}, 2'h0);
		repeat (20) begin
			axr(8'h04, res, 2'h0);
			if (!res[31])
				break;
		end
		if (!w)
			chk(res[7:0], exp);
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev <= '0;
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge clk);
		srst <= 0;
		for (int i = 0; i < 4; i++)
			dev(0, 8'hF4 + i[7:0], 0, i[0] ? 8'hFC : 8'hFF);
		dev(1, 8'hF4, 8'h12, 0);
		dev(0, 8'hF4, 0, 8'hFF);
		dev(0, 8'hFE, 0, 8'h00);
		dev(0, 8'h10, 0, 8'h00);
		chk(count_value, 32'hFFFC);
		dev(1, 8'hF8, 8'h12, 0);
		dev(0, 8'hF8, 0, 8'h12);
		chk(compare_one_value, 32'h1200);
		chk(compare_two_value, 32'h8000);
		dev(1, 8'hFD, 8'hA5, 0);
		chk(timer_control_two, 32'hA5);
		dev(1, 8'hFF, 8'hFE, 0);
		dev(0, 8'hFF, 0, 8'hF0);
		axr(8'h10, res, 2'h2);
		axw(8'h14, 0, 2'h2);
		$display("test map done");
		// pending cleared before unmasking avoids a stale request
		axw(8'h08, 32'h31, 2'h0);
		axw(8'h0C, 32'h1, 2'h0);
		axw(8'h08, 32'h33, 2'h0);
		chk(cpu_irq_priority, 3'h3);
		for (int k = 0; k < 5; k++) begin
			if (k != 2) begin
				dev(1, 8'hFC, c1_t[k], 0);
				dev(1, 8'hFF, c3_t[k], 0);
				axw(8'h0C, 32'h1, 2'h0);
				pulse(k);
				repeat (8) @(posedge clk);
				chk(cpu_irq, 1'b1);
				dev(0, 8'hFE, 0, bit_t[k]);
				dev(0, lo_t[k], 0, val_t[k]);
				dev(0, 8'hFE, 0, 8'h00);
			end
		end
		$display("test sources done");
		dev(1, 8'hF1, 8'h12, 0);
		dev(0, 8'hF1, 0, 8'hFC);
		dev(1, 8'hFC, 8'h80, 0);
		axw(8'h0C, 32'h1, 2'h0);
		pulse(0);
		pulse(3);
		dev(0, 8'hFE, 0, 8'h90);
		dev(0, 8'hF1, 0, 8'hFC);
		axw(8'h0C, 32'h1, 2'h0);
		pulse(0);
		repeat (8) @(posedge clk);
		chk(cpu_irq, 1'b0);
		dev(0, 8'hFE, 0, 8'h90);
		dev(0, 8'hF1, 0, 8'hFC);
		dev(0, 8'hF3, 0, 8'hFC);
		dev(0, 8'hFE, 0, 8'h00);
		$display("test stuck request done");
		dev(1, 8'hFC, 8'h20, 0);
		dev(1, 8'hF5, 8'h55, 0);
		dev(0, 8'hF4, 0, 8'hFF);
		axw(8'h0C, 32'h1, 2'h0);
		repeat (4) pulse(2);
		repeat (8) @(posedge clk);
		chk(cpu_irq, 1'b1);
		chk(count_value, 32'h0000);
		dev(0, 8'hFE, 0, 8'h20);
		dev(0, 8'hF7, 0, 8'h00);
		dev(0, 8'hFE, 0, 8'h20);
		dev(0, 8'hF5, 0, 8'h00);
		dev(0, 8'hFE, 0, 8'h00);
		$display("test overflow done");
		dev(1, 8'hFF, 8'h00, 0);
		axw(8'h0C, 32'h1, 2'h0);
		@(posedge clk);
		ext_pin <= 1'b1;
		repeat (8) @(posedge clk);
		chk(cpu_irq, 1'b1);
		axr(8'h04, res, 2'h0);
		chk(res[30], 1'b1);
		axw(8'h08, 32'h32, 2'h0);
		axw(8'h0C, 32'h1, 2'h0);
		repeat (8) @(posedge clk);
		chk(cpu_irq, 1'b0);
		ext_pin <= 1'b0;
		repeat (8) @(posedge clk);
		chk(cpu_irq, 1'b1);
		$display("test external done");
		report_and_stop();
	end
endmodule // timer_irq_and_count_regs_tb
`default_nettype wire
